// file: bench/dio_port_group_monitor.sv
// Purpose: bus and pad relations of the port group
// Assumes: sees top-level ports only
// Notes:   CE low freezes state, so the ready and irq timing checks require CE
`include "dio_defines.vh"
module dio_port_group_monitor #(
    parameter ADDR_W = 8
) (
    input wire                 CLK,
    input wire                 RST_B,
    input wire                 CE,
    input wire                 PSEL,
    input wire                 PENABLE,
    input wire                 PWRITE,
    input wire [ADDR_W-1:0]    PADDR,
    input wire                 PREADY,
    input wire                 PSLVERR,
    input wire [`DIO_NPIN-1:0] PAD_OE_B,
    input wire [`DIO_NPIN-1:0] PULLUP_EN,
    input wire [`DIO_NPIN-1:0] TTL_SEL,
    input wire [`DIO_NPIN-1:0] ANALOG_SEL,
    input wire                 IRQ_PIN_I,
    input wire                 EXT_IRQ_REQ,
    input wire                 OUT_ONLY_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_first;
        PSEL && PENABLE && !PREADY && CE;
    endsequence
    a_ready_wait: assert property (s_setup ##1 s_first |=> PREADY)
        else $error("ready not one cycle after access");
    a_ready_access: assert property (PREADY |-> PSEL && PENABLE)
        else $error("ready outside access phase");
    a_ready_pulse: assert property (PREADY && CE |=> !PREADY)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_pu_input: assert property ((PULLUP_EN & (~PAD_OE_B | ~`DIO_CAP_PU)) == 0)
        else $error("pull-up on driven or incapable pin");
    a_analog_quiet: assert property (
        (ANALOG_SEL & (~PAD_OE_B | PULLUP_EN | TTL_SEL)) == 0)
        else $error("analog pin driven or pulled");
    a_ttl_cap: assert property ((TTL_SEL & ~`DIO_CAP_PIM) == 0)
        else $error("ttl select on incapable pin");
    a_irq_sync: assert property (
        $past(CE) && $past(CE, 2) && $past(RST_B) && $past(RST_B, 2)
        |-> EXT_IRQ_REQ == $past(IRQ_PIN_I, 2))
        else $error("irq request not two edges behind pin");
    a_out_write: assert property ($changed(OUT_ONLY_O)
        |-> $past(PREADY && PWRITE && PADDR == `DIO_OFS_DATA))
        else $error("output-only pin changed without write");
    a_oe_write: assert property ($changed(PAD_OE_B) |-> $past(PREADY && PWRITE, 2))
        else $error("output enable changed without write");
endmodule

bind dio_port_group dio_port_group_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .CLK(CLK), .RST_B(RST_B), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PAD_OE_B(PAD_OE_B), .PULLUP_EN(PULLUP_EN), .TTL_SEL(TTL_SEL),
    .ANALOG_SEL(ANALOG_SEL), .IRQ_PIN_I(IRQ_PIN_I), .EXT_IRQ_REQ(EXT_IRQ_REQ),
    .OUT_ONLY_O(OUT_ONLY_O));

// file: bench/tb_dio_port_group.sv
// Purpose: self-checking bench for the port group
// Assumes: 80-pin build, APB master with queued response notes for reads and writes
// Notes:   pad checks wait three edges for sync and pad update
`include "dio_defines.vh"
module tb_dio_port_group;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [25:0] ANALOG_PIN_CONFIG_MASK = 26'((1 << `DIO_ANALOG_PIN_CONFIG_W) - 1) << `DIO_ANALOG_PIN_CONFIG_LSB;
    logic        CLK = 0, RST_B = 0, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic        XIN_A_I = 0, XIN_B_I = 0, IRQ_PIN_I = 0;
    logic [7:0]  PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, r_misc;
    logic        PREADY, PSLVERR, OUT_ONLY_O, EXT_IRQ_REQ;
    logic [25:0] PAD_I = 26'h0, PAD_O, PAD_OE_B, PULLUP_EN, TTL_SEL, ANALOG_SEL;
    logic [25:0] r_dir, r_lat, r_pad, ana;
    logic [33:0] note;
    logic [33:0] exp_q[$];
    int          errors = 0, comparisons = 0;
    // PMC and ANALOG_PIN_CONFIG first so later pins are digital
    logic [7:0]  ofs[5] = '{`DIO_OFS_PMC, `DIO_OFS_ANALOG_PIN_CONFIG, `DIO_OFS_PU, `DIO_OFS_PIM, `DIO_OFS_POM};
    logic [25:0] cap[5] = '{`DIO_CAP_PMC, 26'((1 << `DIO_ANALOG_PIN_CONFIG_W) - 1), `DIO_CAP_PU,
                            `DIO_CAP_PIM, `DIO_CAP_POM};

    always #5 CLK = ~CLK;

    dio_port_group uut (
        .CLK(CLK), .RST_B(RST_B), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PAD_I(PAD_I), .PAD_O(PAD_O),
        .PAD_OE_B(PAD_OE_B), .PULLUP_EN(PULLUP_EN), .TTL_SEL(TTL_SEL),
        .ANALOG_SEL(ANALOG_SEL), .XIN_A_I(XIN_A_I), .XIN_B_I(XIN_B_I),
        .IRQ_PIN_I(IRQ_PIN_I), .OUT_ONLY_O(OUT_ONLY_O), .EXT_IRQ_REQ(EXT_IRQ_REQ));

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Note: {check data, error, data}
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [33:0] n);
        exp_q.push_back(n);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {2'b10, e});
    endtask

    task automatic settle;
        repeat (3) @(posedge CLK);
        #1;
    endtask

    always @(posedge CLK) begin
        if (PREADY === 1'b1) begin
            note = exp_q.pop_front();
            chk({PSLVERR, PRDATA & {32{note[33]}}}, note[32:0]);
        end
    end

    initial begin
        repeat (5000) @(posedge CLK);
        errors++;
        $display("watchdog expired");
        wrap_up;
    end

    initial begin
        void'($urandom(32'hF3CFA449));
        repeat (3) @(posedge CLK);
        RST_B <= 1'b1;
        settle;
        chk(33'(PAD_OE_B), 33'(`DIO_RST_DIR));
        chk(33'(ANALOG_SEL), 33'(`DIO_RST_PMC | ANALOG_PIN_CONFIG_MASK));
        chk(33'(PULLUP_EN), 33'(`DIO_RST_PU));
        rd(`DIO_OFS_DIR, 32'(`DIO_RST_DIR));
        rd(`DIO_OFS_PMC, 32'(`DIO_RST_PMC));
        rd(`DIO_OFS_ANALOG_PIN_CONFIG, 32'(`DIO_RST_ANALOG_PIN_CONFIG));
        rd(`DIO_OFS_IMPL, 32'(`DIO_IMPL_80));
        wr(`DIO_OFS_IMPL, 32'h0);
        rd(`DIO_OFS_IMPL, 32'(`DIO_IMPL_80));
        apb(1'b1, 8'h24, 32'hFFFFFFFF, {2'b01, 32'h0});
        apb(1'b0, 8'h24, 32'h0, {2'b11, 32'h0});
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(ofs[i], 32'hFFFFFFFF);
            rd(ofs[i], 32'(cap[i]));
            settle;
            if (i == 2) chk(33'(PULLUP_EN), 33'(`DIO_CAP_PU));
            if (i == 3) chk(33'(TTL_SEL), 33'(`DIO_CAP_PIM));
            wr(ofs[i], 32'h0);
        end
        $display("test capability done");
        r_dir = 26'($urandom);
        r_lat = 26'($urandom);
        r_pad = 26'($urandom);
        r_misc = $urandom;
        @(posedge CLK);
        PAD_I <= r_pad;
        XIN_A_I <= r_misc[0];
        XIN_B_I <= r_misc[1];
        IRQ_PIN_I <= r_misc[2];
        wr(`DIO_OFS_DATA, {6'h01, r_lat});
        wr(`DIO_OFS_DIR, 32'(r_dir));
        wr(`DIO_OFS_PU, 32'hFFFFFFFF);
        settle;
        chk(33'(PAD_OE_B), 33'(r_dir));
        chk(33'(PAD_O & ~PAD_OE_B), 33'(r_lat & ~r_dir));
        chk(33'(PULLUP_EN), 33'(r_dir & `DIO_CAP_PU));
        chk(33'(OUT_ONLY_O), 33'h1);
        rd(`DIO_OFS_DATA, {2'b00, r_misc[2:0], 1'b1,
                           (r_dir & r_pad) | (~r_dir & r_lat)});
        // Raw synced levels regardless of direction
        rd(`DIO_OFS_PIN, {3'h0, r_misc[2:0], r_pad});
        wr(`DIO_OFS_POM, 32'hFFFFFFFF);
        settle;
        chk(33'(PAD_OE_B), 33'(r_dir | (r_lat & `DIO_CAP_POM)));
        chk(33'(PAD_O & ~PAD_OE_B), 33'(r_lat & ~r_dir & ~`DIO_CAP_POM));
        wr(`DIO_OFS_PMC, 32'hFFFFFFFF);
        wr(`DIO_OFS_ANALOG_PIN_CONFIG, 32'hFFFFFFFF);
        settle;
        ana = `DIO_CAP_PMC | ANALOG_PIN_CONFIG_MASK;
        chk(33'(ANALOG_SEL), 33'(ana));
        rd(`DIO_OFS_DATA, {2'b00, r_misc[2:0], 1'b1,
                           ((r_dir & r_pad) | (~r_dir & r_lat)) & ~ana});
        $display("test pins done");
        @(posedge CLK);
        IRQ_PIN_I <= 1'b1;
        settle;
        chk(33'(EXT_IRQ_REQ), 33'h1);
        @(posedge CLK);
        CE <= 1'b0;
        IRQ_PIN_I <= 1'b0;
        settle;
        chk(33'(EXT_IRQ_REQ), 33'h1);
        @(posedge CLK);
        CE <= 1'b1;
        settle;
        chk(33'(EXT_IRQ_REQ), 33'h0);
        $display("test irq done");
        wrap_up;
    end
endmodule

// file: hw/dio_defines.vh
// Purpose: constants for the digital I/O port group
// Assumes: 26 bidirectional pins flattened into one vector
// Notes:   index 0-4 port0, 5-10 port1, 11-15 port2, 16-18 port4,
//          19-20 port5, 21-24 port7, 25 port14
`ifndef DIO_DEFINES_VH
`define DIO_DEFINES_VH

`define DIO_NPIN         26

// Register byte offsets
`define DIO_OFS_DATA     8'h00
`define DIO_OFS_DIR      8'h04
`define DIO_OFS_PU       8'h08
`define DIO_OFS_PIM      8'h0C
`define DIO_OFS_POM      8'h10
`define DIO_OFS_PMC      8'h14
`define DIO_OFS_ANALOG_PIN_CONFIG     8'h18
`define DIO_OFS_PIN      8'h1C
`define DIO_OFS_IMPL     8'h20

// DATA register field positions above the port vector
`define DIO_BIT_OUTONLY  26
`define DIO_BIT_XIN_A    27
`define DIO_BIT_XIN_B    28
`define DIO_BIT_IRQIN    29

// Pins present per package
`define DIO_IMPL_80      26'h3FFFFFF
`define DIO_IMPL_64      26'h1E77BEF

// Per-pin capabilities
`define DIO_CAP_PU       26'h3FF07FF
`define DIO_CAP_PIM      26'h000067B
`define DIO_CAP_POM      26'h00807FC
`define DIO_CAP_PMC      26'h03A07EC
`define DIO_ANALOG_PIN_CONFIG_LSB     11
`define DIO_ANALOG_PIN_CONFIG_W       5

// Reset values
`define DIO_RST_LATCH    26'h0000000
`define DIO_RST_DIR      26'h3FFFFFF
`define DIO_RST_PU       26'h0010000
`define DIO_RST_PIM      26'h0000000
`define DIO_RST_POM      26'h0000000
`define DIO_RST_PMC      26'h00007EC
`define DIO_RST_ANALOG_PIN_CONFIG     5'h1F

`endif

// file: hw/dio_pin.v
// Purpose: combinational control of one bidirectional port pin
// Assumes: dir high means input; ana high means analog use
// Notes:   output enable is active low, pull-up is a level to the pad
module dio_pin (
    input  wire din,
    input  wire latch,
    input  wire dir,
    input  wire pu,
    input  wire pim,
    input  wire pom,
    input  wire ana,
    output wire pad_o,
    output wire pad_oe_b,
    output wire pu_on,
    output wire ttl_on,
    output wire rd
);
    wire drive;

    assign drive    = ~dir & ~ana;
    assign pad_oe_b = ~(drive & (~pom | ~latch));
    assign pad_o    = latch & ~pom;
    assign pu_on    = dir & pu & ~ana;
    assign ttl_on   = pim & ~ana;
    assign rd       = ana ? 1'b0 : (dir ? din : latch);
endmodule

// file: hw/dio_port_group.v
// Purpose: digital I/O port group with APB register access
// Assumes: CLK 100 MHz, RST_B async active low, CE freezes all state
// Notes:   pad inputs pass two flip-flops; analog pins read as zero in DATA, PIN shows raw synced levels
// Function
// - Every I/O pin has an output latch and its own direction bit.
// - Pull-up connects only in input mode with its enable bit set.
// - Port0 bits 0,1,3,4 choose normal or TTL input buffer.
// - Port1 bits 0,1,4,5 choose normal or TTL input buffer.
// - Listed pins choose push-pull or open-drain output per bit.
// - Port0 bits 2,3 switch between digital and analog per bit.
// - Reset: port0 bits 0,1,4 input; bits 2,3 analog.
// - Port1 bits 0-5 selectable analog; all analog after reset.
// - Port2 analog use set by the analog pin configuration register.
// - Reset makes port2 bits 0-4 analog inputs.
// - Port4 bit 1 selectable analog; other port4 pins digital only.
// - Reset puts port4 bits 0-2 in input mode.
// - Port5 bits 0,1 have analog select and pull-up; input after reset.
// - Port7 bit 0 selectable analog; bits 0-3 input after reset.
// - Two resonator pins are input-only, input after reset.
// - One output-only pin driven from its own latch.
// - One input-only pin also serves as interrupt request input.
// - Port14 bit 0 has direction and pull-up; input after reset.
// - Ports 3, 6 and 15 are absent.
// - 64-pin: 24 pins; 80-pin: 30 pins.
// - Pull-up pins: 16 on 64-pin, 21 on 80-pin.
//
// Chosen here: the APB interface to the registers and the register addresses.
`include "dio_defines.vh"

module dio_port_group #(
    parameter PKG80  = 1,
    parameter ADDR_W = 8
) (
    input  wire                  CLK,
    input  wire                  RST_B,
    input  wire                  CE,
    input  wire                  PSEL,
    input  wire                  PENABLE,
    input  wire                  PWRITE,
    input  wire [ADDR_W-1:0]     PADDR,
    input  wire [31:0]           PWDATA,
    output wire [31:0]           PRDATA,
    output wire                  PREADY,
    output wire                  PSLVERR,
    input  wire [`DIO_NPIN-1:0]  PAD_I,
    output wire [`DIO_NPIN-1:0]  PAD_O,
    output wire [`DIO_NPIN-1:0]  PAD_OE_B,
    output wire [`DIO_NPIN-1:0]  PULLUP_EN,
    output wire [`DIO_NPIN-1:0]  TTL_SEL,
    output wire [`DIO_NPIN-1:0]  ANALOG_SEL,
    input  wire                  XIN_A_I,
    input  wire                  XIN_B_I,
    input  wire                  IRQ_PIN_I,
    output wire                  OUT_ONLY_O,
    output wire                  EXT_IRQ_REQ
);
    localparam [`DIO_NPIN-1:0] IMPL = (PKG80 != 0) ? `DIO_IMPL_80 : `DIO_IMPL_64;
    localparam [`DIO_NPIN-1:0] CPU  = `DIO_CAP_PU & IMPL;
    localparam [`DIO_NPIN-1:0] CPIM = `DIO_CAP_PIM & IMPL;
    localparam [`DIO_NPIN-1:0] CPOM = `DIO_CAP_POM & IMPL;
    localparam [`DIO_NPIN-1:0] CPMC = `DIO_CAP_PMC & IMPL;
    localparam [`DIO_ANALOG_PIN_CONFIG_W-1:0] CADPC = IMPL[`DIO_ANALOG_PIN_CONFIG_LSB +: `DIO_ANALOG_PIN_CONFIG_W];

    // Register file
    reg  [`DIO_NPIN-1:0]   latch_ff;
    reg  [`DIO_NPIN-1:0]   dir_ff;
    reg  [`DIO_NPIN-1:0]   pu_ff;
    reg  [`DIO_NPIN-1:0]   pim_ff;
    reg  [`DIO_NPIN-1:0]   pom_ff;
    reg  [`DIO_NPIN-1:0]   pmc_ff;
    reg  [`DIO_ANALOG_PIN_CONFIG_W-1:0] analog_pin_config_ff;
    reg                    out_only_ff;

    // Synchronisers
    reg  [`DIO_NPIN-1:0]   pad_s1_ff;
    reg  [`DIO_NPIN-1:0]   pad_s2_ff;
    reg  [2:0]             xin_s1_ff;
    reg  [2:0]             xin_s2_ff;

    // Registered pad controls
    reg  [`DIO_NPIN-1:0]   pad_o_ff;
    reg  [`DIO_NPIN-1:0]   pad_oe_b_ff;
    reg  [`DIO_NPIN-1:0]   pu_on_ff;
    reg  [`DIO_NPIN-1:0]   ttl_ff;
    reg  [`DIO_NPIN-1:0]   ana_ff;

    // Bus response
    reg  [31:0]            prdata_ff;
    reg                    pready_ff;
    reg                    pslverr_ff;
    reg  [31:0]            nxt_prdata;
    reg                    nxt_slverr;

    wire [`DIO_NPIN-1:0]   ana_eff;
    wire [`DIO_NPIN-1:0]   nxt_pad_o;
    wire [`DIO_NPIN-1:0]   nxt_pad_oe_b;
    wire [`DIO_NPIN-1:0]   nxt_pu_on;
    wire [`DIO_NPIN-1:0]   nxt_ttl;
    wire [`DIO_NPIN-1:0]   pin_rd;
    wire [`DIO_NPIN-1:0]   wdat;
    wire                   access;
    wire                   wr_en;

    assign wdat   = PWDATA[`DIO_NPIN-1:0];
    assign access = PSEL & PENABLE;
    // Write lands on the edge that completes the transfer
    assign wr_en  = access & pready_ff & PWRITE & ~pslverr_ff;

    assign ana_eff = (pmc_ff & CPMC) |
                     ({{(`DIO_NPIN-`DIO_ANALOG_PIN_CONFIG_W){1'b0}}, analog_pin_config_ff & CADPC}
                      << `DIO_ANALOG_PIN_CONFIG_LSB);

    genvar gi;
    generate
        for (gi = 0; gi < `DIO_NPIN; gi = gi + 1) begin : g_pin
            dio_pin u_pin (
                .din      (pad_s2_ff[gi]),
                .latch    (latch_ff[gi]),
                .dir      (dir_ff[gi]),
                .pu       (pu_ff[gi]),
                .pim      (pim_ff[gi]),
                .pom      (pom_ff[gi]),
                .ana      (ana_eff[gi]),
                .pad_o    (nxt_pad_o[gi]),
                .pad_oe_b (nxt_pad_oe_b[gi]),
                .pu_on    (nxt_pu_on[gi]),
                .ttl_on   (nxt_ttl[gi]),
                .rd       (pin_rd[gi])
            );
        end
    endgenerate

    // Two-stage input synchronisers; only stage two is read
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pad_s1_ff <= {`DIO_NPIN{1'b0}};
            pad_s2_ff <= {`DIO_NPIN{1'b0}};
            xin_s1_ff <= 3'h0;
            xin_s2_ff <= 3'h0;
        end else if (CE) begin
            pad_s1_ff <= PAD_I;
            pad_s2_ff <= pad_s1_ff;
            xin_s1_ff <= {IRQ_PIN_I, XIN_B_I, XIN_A_I};
            xin_s2_ff <= xin_s1_ff;
        end
    end

    // Control registers
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            latch_ff    <= `DIO_RST_LATCH;
            dir_ff      <= `DIO_RST_DIR;
            pu_ff       <= `DIO_RST_PU;
            pim_ff      <= `DIO_RST_PIM;
            pom_ff      <= `DIO_RST_POM;
            pmc_ff      <= `DIO_RST_PMC;
            analog_pin_config_ff     <= `DIO_RST_ANALOG_PIN_CONFIG;
            out_only_ff <= 1'b0;
        end else if (CE && wr_en) begin
            case (PADDR[7:0])
                `DIO_OFS_DATA: begin
                    latch_ff    <= wdat & IMPL;
                    out_only_ff <= PWDATA[`DIO_BIT_OUTONLY];
                end
                `DIO_OFS_DIR: begin
                    // Absent pins stay inputs so they never drive
                    dir_ff <= wdat | ~IMPL;
                end
                `DIO_OFS_PU: begin
                    pu_ff <= wdat & CPU;
                end
                `DIO_OFS_PIM: begin
                    pim_ff <= wdat & CPIM;
                end
                `DIO_OFS_POM: begin
                    pom_ff <= wdat & CPOM;
                end
                `DIO_OFS_PMC: begin
                    pmc_ff <= wdat & CPMC;
                end
                `DIO_OFS_ANALOG_PIN_CONFIG: begin
                    analog_pin_config_ff <= PWDATA[`DIO_ANALOG_PIN_CONFIG_W-1:0] & CADPC;
                end
                default: begin
                    latch_ff <= latch_ff;
                end
            endcase
        end
    end

    // Pad controls registered so every output is a flop
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pad_o_ff    <= {`DIO_NPIN{1'b0}};
            pad_oe_b_ff <= {`DIO_NPIN{1'b1}};
            pu_on_ff    <= {`DIO_NPIN{1'b0}};
            ttl_ff      <= {`DIO_NPIN{1'b0}};
            ana_ff      <= {`DIO_NPIN{1'b0}};
        end else if (CE) begin
            pad_o_ff    <= nxt_pad_o;
            pad_oe_b_ff <= nxt_pad_oe_b;
            pu_on_ff    <= nxt_pu_on;
            ttl_ff      <= nxt_ttl;
            ana_ff      <= ana_eff;
        end
    end

    // Read mux and decode
    always @* begin
        nxt_prdata = 32'h00000000;
        nxt_slverr = 1'b0;
        case (PADDR[7:0])
            `DIO_OFS_DATA: begin
                // Pin in input mode, latch in output mode
                nxt_prdata = {2'h0, xin_s2_ff, out_only_ff, pin_rd & IMPL};
            end
            `DIO_OFS_DIR: begin
                nxt_prdata = {6'h00, dir_ff};
            end
            `DIO_OFS_PU: begin
                nxt_prdata = {6'h00, pu_ff};
            end
            `DIO_OFS_PIM: begin
                nxt_prdata = {6'h00, pim_ff};
            end
            `DIO_OFS_POM: begin
                nxt_prdata = {6'h00, pom_ff};
            end
            `DIO_OFS_PMC: begin
                nxt_prdata = {6'h00, pmc_ff};
            end
            `DIO_OFS_ANALOG_PIN_CONFIG: begin
                nxt_prdata = {27'h0000000, analog_pin_config_ff};
            end
            `DIO_OFS_PIN: begin
                nxt_prdata = {3'h0, xin_s2_ff, pad_s2_ff & IMPL};
            end
            `DIO_OFS_IMPL: begin
                nxt_prdata = {6'h00, IMPL};
            end
            default: begin
                nxt_slverr = 1'b1;
            end
        endcase
        if (PADDR[ADDR_W-1:0] > 8'h20)
            nxt_slverr = 1'b1;
    end

    // One wait state: pready rises in the second access cycle
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (CE) begin
            pready_ff  <= access & ~pready_ff;
            if (access && !pready_ff) begin
                prdata_ff  <= PWRITE ? 32'h00000000 : nxt_prdata;
                pslverr_ff <= nxt_slverr;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    assign PRDATA      = prdata_ff;
    assign PREADY      = pready_ff;
    assign PSLVERR     = pslverr_ff;
    assign PAD_O       = pad_o_ff;
    assign PAD_OE_B    = pad_oe_b_ff;
    assign PULLUP_EN   = pu_on_ff;
    assign TTL_SEL     = ttl_ff;
    assign ANALOG_SEL  = ana_ff;
    assign OUT_ONLY_O  = out_only_ff;
    assign EXT_IRQ_REQ = xin_s2_ff[2];
endmodule
